// ### src/becs_pkg.sv
// Package with event codes, field widths and reset values for the bus event counter
package becs_pkg;
  localparam int becs_code_w = 8;
  localparam int becs_umask_w = 8;
  localparam int becs_cnt_w = 40;
  localparam int becs_nev = 6;
  localparam logic [7:0] becs_code_bnr = 8'h61;
  localparam logic [7:0] becs_code_data_ready_strobe = 8'h62;
  localparam logic [7:0] becs_code_lock = 8'h63;
  localparam logic [7:0] becs_code_rcv = 8'h64;
  localparam logic [7:0] becs_code_brd = 8'h65;
  localparam logic [7:0] becs_code_rfo = 8'h66;
  localparam logic [39:0] becs_cnt_reset = 40'h00_0000_0000;
  localparam logic [5:0] becs_hit_reset = 6'h00;
  // Outstanding transaction count at which bus-not-ready is driven
  localparam logic [3:0] becs_bnr_thresh = 4'hE;
  localparam logic [3:0] becs_out_reset = 4'h0;
  // Index of each event within the hit vector
  localparam int becs_ix_bnr = 0;
  localparam int becs_ix_data_ready_strobe = 1;
  localparam int becs_ix_lock = 2;
  localparam int becs_ix_rcv = 3;
  localparam int becs_ix_brd = 4;
  localparam int becs_ix_rfo = 5;
  typedef enum logic [2:0] {
    becs_idle_type = 3'h1,
    becs_count_type = 3'h2,
    becs_hold_type = 3'h4
  } becs_state_type;
endpackage

// ### src/becs_match_if.sv
// Interface carrying bus conditions and the match result between modules
`timescale 1ns/1ps
interface becs_match_if;
  logic [5:0] cond;
  logic [7:0] code;
  logic [7:0] umask;
  logic [7:0] umask_filter;
  logic umask_filter_en;
  logic [5:0] hit;
  modport top (output cond, output code, output umask, output umask_filter, output umask_filter_en, input hit);
  modport matcher (input cond, input code, input umask, input umask_filter, input umask_filter_en, output hit);
endinterface

// ### src/becs_match.sv
// Event code comparator: one hit per bus condition whose code is selected
`timescale 1ns/1ps
module becs_match (
  becs_match_if.matcher m
);
  localparam logic [7:0] codes [6] = '{becs_pkg::becs_code_bnr, becs_pkg::becs_code_data_ready_strobe,
    becs_pkg::becs_code_lock, becs_pkg::becs_code_rcv, becs_pkg::becs_code_brd, becs_pkg::becs_code_rfo};
  logic umask_ok;
  // Opaque qualifier; filters only when a meaning is supplied
  assign umask_ok = !m.umask_filter_en || ((m.umask & m.umask_filter) != 8'h00);
  genvar i;
  generate
    for (i = 0; i < becs_pkg::becs_nev; i++) begin : g_ev
      assign m.hit[i] = m.cond[i] && (m.code == codes[i]) && umask_ok;
    end
  endgenerate
endmodule

// ### src/becs_top.sv
// Bus event counter with selectable front-side bus event
`timescale 1ns/1ps
module becs_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic count_enable,
  input wire logic [7:0] event_select,
  input wire logic [7:0] unit_mask,
  input wire logic [7:0] unit_mask_filter,
  input wire logic unit_mask_filter_en,
  input wire logic any_thread_qualifier,
  input wire logic counter_clear,
  input wire logic txn_start,
  input wire logic txn_done,
  input wire logic data_ready_strobe_in,
  input wire logic data_write_own,
  input wire logic data_receive_busy,
  input wire logic lock_uncacheable,
  input wire logic lock_line_split,
  input wire logic lock_page_walk,
  input wire logic burst_read_issue,
  input wire logic txn_is_rfo,
  input wire logic rfo_store_miss,
  input wire logic rfo_locked,
  input wire logic bus_not_ready_in,
  output logic bus_not_ready_signal,
  output logic bus_lock_signal,
  output logic txn_grant,
  output logic [39:0] event_count,
  output logic counting
);
  becs_match_if mif ();
  becs_match u_match (.m(mif));

  // Pins from other agents: two-flop synchronisers
  logic [1:0] bnr_in_s1_reg, bnr_in_s2_reg;
  logic [1:0] bnr_in_s1_next;
  assign bnr_in_s1_next = {data_ready_strobe_in, bus_not_ready_in};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bnr_in_s1_reg <= 2'h0;
      bnr_in_s2_reg <= 2'h0;
    end else if (clk_en) begin
      bnr_in_s1_reg <= bnr_in_s1_next;
      bnr_in_s2_reg <= bnr_in_s1_reg;
    end
  end
  logic ext_bnr, data_ready_strobe_seen;
  assign ext_bnr = bnr_in_s2_reg[0];
  assign data_ready_strobe_seen = bnr_in_s2_reg[1];

  // Outstanding transaction tracking and bus output drive
  logic [3:0] out_reg, out_next;
  logic bnr_reg, bnr_next, bnr_prev_reg;
  logic lock_reg, lock_next, grant_reg, grant_next;
  logic issue;
  always_comb begin
    grant_next = !bnr_reg && !ext_bnr;
    issue = txn_start && grant_reg;
    out_next = out_reg;
    if (issue && !(txn_done && out_reg != 4'h0)) begin
      out_next = out_reg + 4'h1;
    end else if (!issue && txn_done && out_reg != 4'h0) begin
      out_next = out_reg - 4'h1;
    end
    bnr_next = (out_next >= becs_pkg::becs_bnr_thresh);
    lock_next = lock_uncacheable || lock_line_split || lock_page_walk;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_reg <= becs_pkg::becs_out_reset;
      bnr_reg <= 1'b0;
      bnr_prev_reg <= 1'b0;
      lock_reg <= 1'b0;
      grant_reg <= 1'b0;
    end else if (clk_en) begin
      out_reg <= out_next;
      bnr_reg <= bnr_next;
      bnr_prev_reg <= bnr_reg;
      lock_reg <= lock_next;
      grant_reg <= grant_next;
    end
  end

  // Bus conditions, registered one per cycle
  logic [5:0] cond_reg, cond_next;
  always_comb begin
    cond_next = becs_pkg::becs_hit_reset;
    cond_next[becs_pkg::becs_ix_bnr] = bnr_reg && !bnr_prev_reg;
    cond_next[becs_pkg::becs_ix_data_ready_strobe] = data_ready_strobe_seen && data_write_own;
    cond_next[becs_pkg::becs_ix_lock] = lock_reg;
    cond_next[becs_pkg::becs_ix_rcv] = data_receive_busy;
    cond_next[becs_pkg::becs_ix_brd] = burst_read_issue && !txn_is_rfo;
    cond_next[becs_pkg::becs_ix_rfo] = txn_is_rfo && (rfo_store_miss || rfo_locked);
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cond_reg <= becs_pkg::becs_hit_reset;
    end else if (clk_en) begin
      cond_reg <= cond_next;
    end
  end

  assign mif.cond = cond_reg;
  assign mif.code = event_select;
  assign mif.umask = unit_mask;
  assign mif.umask_filter = unit_mask_filter;
  assign mif.umask_filter_en = unit_mask_filter_en;

  // Counter control
  becs_pkg::becs_state_type state_reg, state_next;
  logic [39:0] cnt_reg, cnt_next;
  logic any_hit;
  // Thread qualifier deliberately unused: bus events are processor-wide
  logic thread_ignored;
  assign thread_ignored = any_thread_qualifier;
  assign any_hit = |mif.hit;
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      becs_pkg::becs_idle_type: begin
        if (count_enable) begin
          state_next = becs_pkg::becs_count_type;
        end
      end
      becs_pkg::becs_count_type: begin
        if (!count_enable) begin
          state_next = becs_pkg::becs_hold_type;
        end else if (any_hit || (thread_ignored && 1'b0)) begin
          cnt_next = cnt_reg + 40'h00_0000_0001;
        end
      end
      becs_pkg::becs_hold_type: begin
        if (count_enable) begin
          state_next = becs_pkg::becs_count_type;
        end
      end
      default: begin
        state_next = becs_pkg::becs_idle_type;
      end
    endcase
    if (counter_clear) begin
      cnt_next = becs_pkg::becs_cnt_reset;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= becs_pkg::becs_idle_type;
      cnt_reg <= becs_pkg::becs_cnt_reset;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign bus_not_ready_signal = bnr_reg;
  assign bus_lock_signal = lock_reg;
  assign txn_grant = grant_reg;
  assign event_count = cnt_reg;
  assign counting = state_reg[1];
endmodule

// ### dv/becs_chk.sv
// Port checker for the bus event counter
`timescale 1ns/1ps
module becs_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] event_select,
  input wire logic unit_mask_filter_en,
  input wire logic counter_clear,
  input wire logic lock_uncacheable,
  input wire logic lock_line_split,
  input wire logic lock_page_walk,
  input wire logic data_receive_busy,
  input wire logic bus_not_ready_in,
  input wire logic bus_not_ready_signal,
  input wire logic bus_lock_signal,
  input wire logic txn_grant,
  input wire logic [39:0] event_count,
  input wire logic counting
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic lock_any, live;
  assign lock_any = lock_uncacheable | lock_line_split | lock_page_walk;
  assign live = clk_en && counting && !counter_clear && !unit_mask_filter_en;
  sequence lock_s; live && event_select == 8'h63 && lock_any ##1 (live && event_select == 8'h63) [*2]; endsequence
  sequence rcv_s; live && event_select == 8'h64 && data_receive_busy ##1 live && event_select == 8'h64; endsequence
  lock_follow_a: assert property (clk_en |=> bus_lock_signal == $past(lock_any)) else $error("lock pin");
  lock_count_a: assert property (lock_s |=> event_count == $past(event_count) + 40'h1) else $error("lock");
  rcv_count_a: assert property (rcv_s |=> event_count == $past(event_count) + 40'h1) else $error("rcv");
  count_step_a: assert property (clk_en && !counter_clear |=> event_count - $past(event_count) <= 40'h1)
    else $error("jump");
  clear_zero_a: assert property (clk_en && counter_clear |=> event_count == 40'h0) else $error("clear");
  freeze_hold_a: assert property (!clk_en |=> $stable(event_count) && $stable(bus_lock_signal))
    else $error("freeze");
  odd_code_a: assert property ((clk_en && !counter_clear && (event_select < 8'h61 || event_select > 8'h66)) [*4]
    |=> $stable(event_count)) else $error("odd code");
  idle_hold_a: assert property ((clk_en && !counting && !counter_clear) [*2] |=> $stable(event_count))
    else $error("idle");
  own_block_a: assert property (bus_not_ready_signal && $past(bus_not_ready_signal) |-> !txn_grant)
    else $error("own grant");
  ext_block_a: assert property ((clk_en && bus_not_ready_in) [*4] |-> !txn_grant) else $error("ext grant");
endmodule
bind becs_top becs_chk u_chk (.sys_clk, .rst, .clk_en, .event_select, .unit_mask_filter_en, .counter_clear,
  .lock_uncacheable, .lock_line_split, .lock_page_walk, .data_receive_busy, .bus_not_ready_in,
  .bus_not_ready_signal, .bus_lock_signal, .txn_grant, .event_count, .counting);

// ### dv/becs_bus_agent.sv
// Other bus agents: complete granted requests, drive their not-ready pin
`timescale 1ns/1ps
module becs_bus_agent (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic txn_start,
  input wire logic txn_grant,
  input wire logic stall,
  input wire logic busy,
  output logic txn_done,
  output logic bus_not_ready_in
);
  int pend;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend <= 0;
      txn_done <= 1'b0;
      bus_not_ready_in <= 1'b0;
    end else begin
      // Slow partner: one completion every other cycle at most
      txn_done <= !stall && pend > 0 && !txn_done;
      pend <= pend + int'(txn_start && txn_grant) - int'(txn_done);
      bus_not_ready_in <= busy;
    end
  end
endmodule

// ### dv/becs_top_tb_top.sv
// Bench for event selection, counting and the not-ready handshake
`timescale 1ns/1ps
module becs_top_tb_top;
  logic sys_clk = 1'b0, rst = 1'b1, count_enable = 1'b0, counter_clear = 1'b0, any_thread_qualifier = 1'b0;
  logic txn_start = 1'b0, stall = 1'b1, busy = 1'b0, write_own = 1'b0, clk_en = 1'b1;
  logic [7:0] event_select = 8'h00, unit_mask = 8'h00;
  logic [8:0] stim = 9'h000;
  logic txn_done, bus_not_ready_in, bus_not_ready_signal, bus_lock_signal, txn_grant, counting;
  logic [39:0] event_count;
  logic [39:0] exp_q[$];
  int num_errors = 0, samples_checked = 0;
  event chk_ev;
  becs_top DUT (.sys_clk, .rst, .clk_en, .count_enable, .event_select, .unit_mask,
    .unit_mask_filter(8'h00), .unit_mask_filter_en(1'b0), .any_thread_qualifier, .counter_clear, .txn_start,
    .txn_done, .data_ready_strobe_in(stim[0]), .data_write_own(write_own), .data_receive_busy(stim[4]),
    .lock_uncacheable(stim[1]), .lock_line_split(stim[2]), .lock_page_walk(stim[3]), .burst_read_issue(stim[5]),
    .txn_is_rfo(stim[6]), .rfo_store_miss(stim[7]), .rfo_locked(stim[8]), .bus_not_ready_in,
    .bus_not_ready_signal, .bus_lock_signal, .txn_grant, .event_count, .counting);
  becs_bus_agent u_agent (.sys_clk, .rst, .txn_start, .txn_grant, .stall, .busy, .txn_done, .bus_not_ready_in);
  initial forever #4 sys_clk = ~sys_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmp_count(input logic [39:0] exp);
    samples_checked++;
    if (event_count !== exp) begin
      num_errors++;
      $display("[FAIL] %0t count %h expected %h", $time, event_count, exp);
    end
  endtask
  // Clear, pulse the inputs n times, let the pipeline drain, note the total
  task automatic run_ev(input logic [7:0] code, input logic [8:0] mask, input logic own, input logic [39:0] hit);
    int n;
    n = $urandom_range(8, 1);
    event_select = code;
    write_own = own;
    unit_mask = 8'($urandom);
    any_thread_qualifier = 1'($urandom);
    counter_clear = 1'b1;
    tick(1);
    counter_clear = 1'b0;
    repeat (n) begin
      stim = mask;
      tick(1);
      stim = 9'h000;
      tick(1);
    end
    tick(8);
    write_own = 1'b0;
    exp_q.push_back(hit * 40'(n));
    ->chk_ev;
    $display("Test code %h mask %h done", code, mask);
  endtask
  task automatic wrap_up();
    $display("Checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial forever begin
    @(chk_ev);
    cmp_count(exp_q.pop_front());
  end
  initial begin
    #20000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    void'($urandom(32'h777B5D76));
    tick(6);
    rst = 1'b0;
    count_enable = 1'b1;
    tick(2);
    run_ev(8'h62, 9'h001, 1'b1, 40'h1);
    run_ev(8'h62, 9'h001, 1'b0, 40'h0);
    run_ev(8'h63, 9'h002 << $urandom_range(2, 0), 1'b0, 40'h1);
    run_ev(8'h64, 9'h010, 1'b0, 40'h1);
    run_ev(8'h64, 9'h002, 1'b0, 40'h0);
    run_ev(8'h65, 9'h020, 1'b0, 40'h1);
    run_ev(8'h65, 9'h060, 1'b0, 40'h0);
    run_ev(8'h66, 9'h0E0, 1'b0, 40'h1);
    run_ev(8'h66, 9'h160, 1'b0, 40'h1);
    run_ev(8'h67, 9'h1FF, 1'b1, 40'h0);
    // Frozen clock enable: lock held high must not be counted
    event_select = 8'h63;
    stim = 9'h002;
    clk_en = 1'b0;
    tick(5);
    stim = 9'h000;
    tick(2);
    clk_en = 1'b1;
    tick(8);
    exp_q.push_back(40'h0);
    ->chk_ev;
    $display("Test clock enable freeze done");
    event_select = 8'h61;
    counter_clear = 1'b1;
    tick(1);
    counter_clear = 1'b0;
    txn_start = 1'b1;
    tick(20);
    txn_start = 1'b0;
    stall = 1'b0;
    tick(40);
    exp_q.push_back(40'h1);
    ->chk_ev;
    busy = 1'b1;
    tick(6);
    busy = 1'b0;
    tick(4);
    $display("Test not-ready handshake done");
    wrap_up();
  end
endmodule
